/* verilog/ism_pkg.sv */
package ism_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_BUS_MODE   = 8'h00;
  localparam logic [7:0] OFS_OPER_MODE  = 8'h04;
  localparam logic [7:0] OFS_INT_STATUS = 8'h08;
  localparam logic [7:0] OFS_INT_ENABLE = 8'h0c;
  localparam logic [7:0] OFS_MITIGATION = 8'h10;

  // Bus mode and operating mode fields
  localparam int SOFT_RESET_BIT = 0;
  localparam int RX_START_BIT   = 0;
  localparam int TX_START_BIT   = 1;
  localparam logic [31:0] OPER_MODE_MASK = 32'h0000_0003;

  // Status bit positions
  localparam int ST_TX_DONE    = 0;
  localparam int ST_TX_STOPPED = 1;
  localparam int ST_TX_UNAVAIL = 2;
  localparam int ST_RX_DONE    = 6;
  localparam int ST_RX_UNAVAIL = 7;
  localparam int ST_RX_STOPPED = 8;
  localparam int ST_ABN_SUM    = 15;
  localparam int ST_NOR_SUM    = 16;
  localparam int ST_RX_STATE   = 17;
  localparam int ST_TX_STATE   = 20;

  // Event groups
  localparam logic [31:0] NORMAL_GROUP   = 32'h0000_4845;
  localparam logic [31:0] ABNORMAL_GROUP = 32'h0c00_37ba;
  localparam logic [31:0] EVENT_MASK     = NORMAL_GROUP | ABNORMAL_GROUP;
  localparam logic [31:0] MITIGATED      = 32'h0000_0041;

  // Mitigation control fields
  localparam int MIT_CNT_W      = 3;
  localparam int MIT_TMR_W      = 4;
  localparam int MIT_RX_TMR_LSB = 0;
  localparam int MIT_RX_CNT_LSB = 4;
  localparam int MIT_TX_TMR_LSB = 8;
  localparam int MIT_TX_CNT_LSB = 12;
  localparam logic [31:0] MITIGATION_MASK = 32'h0000_7f7f;

  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_NS       = 5120;
  localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] TICK_LAST = 8'(TICK_CYCLES - 1);
  localparam int RESET_WAIT_CYCLES = 50;
  localparam logic [5:0] RESET_WAIT_LAST = 6'(RESET_WAIT_CYCLES - 1);

  // Process states, Gray along stopped-running-suspended
  typedef enum logic [1:0] {
    PROC_STOPPED   = 2'h0,
    PROC_RUNNING   = 2'h1,
    PROC_SUSPENDED = 2'h3
  } ism_proc_t;

  typedef struct packed {
    ism_proc_t state;
    logic      acquire;
    logic      suspended;
    logic      stopped;
  } ism_pstep_t;

endpackage

/* verilog/ism_rst_sync.sv */
module ism_rst_sync (
  // Clock and raw reset
  input  wire logic mclk,
  input  wire logic arst_n,
  // Released reset
  output logic      rst_n
);

  typedef struct packed {
    logic first;
    logic second;
  } ism_sync_t;

  ism_sync_t s;
  ism_sync_t next_s;

  always_comb
  begin
    next_s.first = 1'b1;
    next_s.second = s.first;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign rst_n = s.second;

endmodule

/* verilog/ism_mitigator.sv */
module ism_mitigator (
  // Clock and reset
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  // Configuration, zero disables that limit
  input  wire logic [ism_pkg::MIT_CNT_W-1:0] cnt_cfg,
  input  wire logic [ism_pkg::MIT_TMR_W-1:0] tmr_cfg,
  // Events
  input  wire logic                        tick,
  input  wire logic                        event_in,
  input  wire logic                        flush,
  // Interrupt to signal now
  output logic                             fire
);

  typedef struct packed {
    logic                        pending;
    logic [ism_pkg::MIT_CNT_W-1:0] cnt_left;
    logic [ism_pkg::MIT_TMR_W-1:0] tmr_left;
    logic                        tmr_run;
  } ism_mit_t;

  ism_mit_t s;
  ism_mit_t next_s;
  logic     cnt_on;
  logic     tmr_on;
  logic [ism_pkg::MIT_CNT_W-1:0] cnt_base;

  assign cnt_on = cnt_cfg != '0;
  assign tmr_on = tmr_cfg != '0;
  assign cnt_base = s.pending ? s.cnt_left : cnt_cfg;

  always_comb
  begin
    next_s = s;
    fire = 1'b0;
    // RL12: both off passes through; a batch left from before goes out now
    if (!cnt_on && !tmr_on)
      fire = event_in || s.pending;
    else
    begin
      // RL14: hold and count
      if (event_in)
      begin
        next_s.pending = 1'b1;
        if (cnt_on)
        begin
          next_s.cnt_left = cnt_base - 3'h1;
          // RL13: counter limit reached
          if (cnt_base == 3'h1)
            fire = 1'b1;
        end
        if (tmr_on && !s.tmr_run)
        begin
          next_s.tmr_run = 1'b1;
          next_s.tmr_left = tmr_cfg;
        end
      end
      // RL13: timer limit reached
      if (s.tmr_run && tick)
      begin
        if (s.tmr_left <= 4'h1)
          fire = 1'b1;
        else
          next_s.tmr_left = s.tmr_left - 4'h1;
      end
      // RL16: process suspended or stopped
      if (flush && (s.pending || event_in))
        fire = 1'b1;
    end
    // RL15: reload after signalling
    if (fire)
    begin
      next_s.pending = 1'b0;
      next_s.tmr_run = 1'b0;
      next_s.cnt_left = cnt_cfg;
      next_s.tmr_left = tmr_cfg;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

endmodule

/* verilog/ism_top.sv */
// Behaviour
// RL1: a latched event interrupts only when its enable bit is set.
// RL2: normal summary covers status bits 0, 2, 6, 11 and 14.
// RL3: abnormal summary covers bits 1,3,4,5,7,8,9,10,12,13,26,27.
// RL4: interrupt output is driven low while either summary bit is set.
// RL5: writing one clears a status bit; writing zero leaves it.
// RL6: a summary clears once all its enabled members are cleared.
// RL7: interrupt output released when both summaries are clear.
// RL8: events are not queued; a recurring set bit adds nothing.
// RL9: simultaneous events give one interrupt; new one only after clearing.
// RL10: clearing write drops interrupt a cycle; remaining event reasserts.
// RL11: separate receive and transmit counters and timers, one register.
// RL12: a counter or timer programmed to zero has no effect.
// RL13: counter bounds pending interrupts, timer bounds pending time.
// RL14: in mitigation, decrement counter and start idle timer instead.
// RL15: signal pending on counter or timer expiry, then reload both.
// RL16: signal pending interrupts at once on suspend or stop.
// RL17: host waits 50 clocks after any reset before first access.
// RL18: host initialises config, bus mode, enables, list bases, then mode.
// RL19: host rewrites serial interface defaults before start in 10 Mb/s.
// RL20: host starts receive after the setup frame when filtering.
// RL21: started processes run and acquire descriptors, independently.
// RL22: masked events still latch but feed no summary or interrupt.
//
// Our own choices: the address map and the plain strobed port.
module ism_top (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Event pulses from the engines
  input  wire logic [31:0] ev_in,
  input  wire logic        rx_done,
  input  wire logic        tx_done,
  // Receive process status
  input  wire logic        rx_buf_unavail,
  input  wire logic        rx_poll,
  input  wire logic        rx_busy,
  // Transmit process status
  input  wire logic        tx_buf_unavail,
  input  wire logic        tx_poll,
  input  wire logic        tx_busy,
  // Process control
  output logic             rx_running,
  output logic             tx_running,
  output logic             rx_acquire,
  output logic             tx_acquire,
  // Host side
  output logic             dev_ready,
  output logic             int_n
);

  typedef struct packed {
    logic [31:0]       bus_mode;
    logic [31:0]       oper_mode;
    logic [31:0]       status;
    logic [31:0]       enable;
    logic [31:0]       mitig;
    ism_pkg::ism_proc_t rx_st;
    ism_pkg::ism_proc_t tx_st;
    logic              rx_acq;
    logic              tx_acq;
    logic [7:0]        tick_cnt;
    logic              tick;
    logic [5:0]        wait_cnt;
    logic              ready;
    logic              int_act;
    logic [31:0]       rdata;
  } ism_state_t;

  ism_state_t          s;
  ism_state_t          next_s;
  logic                rst_n;
  ism_pkg::ism_pstep_t rx_step;
  ism_pkg::ism_pstep_t tx_step;
  logic                rx_fire;
  logic                tx_fire;
  logic                wr_ok;
  logic                rd_ok;
  logic [31:0]         set_bits;
  logic [31:0]         clr_bits;
  logic                any_sum;
  logic                clr_hit;

  function automatic logic group_sum(
    input logic [31:0] st,
    input logic [31:0] en,
    input logic [31:0] grp
  );
    // RL1: only enabled members count
    group_sum = |(st & en & grp);
  endfunction

  // Stop and suspend of a process latch their own status bits
  function automatic logic [31:0] proc_events(
    input logic [31:0]         bits,
    input ism_pkg::ism_pstep_t step,
    input int                  stop_pos,
    input int                  unavail_pos
  );
    logic [31:0] r;
    r = bits;
    r[stop_pos] = r[stop_pos] | step.stopped;
    r[unavail_pos] = r[unavail_pos] | step.suspended;
    return r;
  endfunction

  // Summaries are rebuilt on every read, so they always match the bits
  function automatic logic [31:0] status_view(
    input logic [31:0]        st,
    input logic [31:0]        en,
    input ism_pkg::ism_proc_t rx,
    input ism_pkg::ism_proc_t tx
  );
    logic [31:0] r;
    r = st;
    // RL6: summaries follow the enabled members
    r[ism_pkg::ST_NOR_SUM] = group_sum(st, en, ism_pkg::NORMAL_GROUP);
    r[ism_pkg::ST_ABN_SUM] = group_sum(st, en, ism_pkg::ABNORMAL_GROUP);
    r[ism_pkg::ST_RX_STATE +: 2] = rx;
    r[ism_pkg::ST_TX_STATE +: 2] = tx;
    return r;
  endfunction

  function automatic ism_pkg::ism_pstep_t proc_step(
    input ism_pkg::ism_proc_t st,
    input logic               start,
    input logic               unavail,
    input logic               poll,
    input logic               busy
  );
    ism_pkg::ism_pstep_t r;
    r = '{state: st, acquire: 1'b0, suspended: 1'b0, stopped: 1'b0};
    case (st)
      ism_pkg::PROC_STOPPED:
      begin
        // RL21: start into running
        if (start)
        begin
          r.state = ism_pkg::PROC_RUNNING;
          r.acquire = 1'b1;
        end
      end
      ism_pkg::PROC_RUNNING:
      begin
        // The frame in flight completes before the stop takes effect
        if (!start && !busy)
        begin
          r.state = ism_pkg::PROC_STOPPED;
          r.stopped = 1'b1;
        end
        else if (unavail)
        begin
          r.state = ism_pkg::PROC_SUSPENDED;
          r.suspended = 1'b1;
        end
      end
      ism_pkg::PROC_SUSPENDED:
      begin
        if (!start)
        begin
          r.state = ism_pkg::PROC_STOPPED;
          r.stopped = 1'b1;
        end
        else if (poll)
        begin
          r.state = ism_pkg::PROC_RUNNING;
          r.acquire = 1'b1;
        end
      end
      default:
      begin
        r.state = ism_pkg::PROC_STOPPED;
      end
    endcase
    return r;
  endfunction

  ism_rst_sync u_rst_sync (
    .mclk   (mclk),
    .arst_n (arst_n),
    .rst_n  (rst_n)
  );

  // RL21: each process steps on its own
  assign rx_step = proc_step(s.rx_st, s.oper_mode[ism_pkg::RX_START_BIT],
                             rx_buf_unavail, rx_poll, rx_busy);
  assign tx_step = proc_step(s.tx_st, s.oper_mode[ism_pkg::TX_START_BIT],
                             tx_buf_unavail, tx_poll, tx_busy);

  // RL12: zero limits are bypassed inside each mitigator
  // RL11: one mitigator per direction
  ism_mitigator u_rx_mit (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .cnt_cfg  (s.mitig[ism_pkg::MIT_RX_CNT_LSB +: ism_pkg::MIT_CNT_W]),
    .tmr_cfg  (s.mitig[ism_pkg::MIT_RX_TMR_LSB +: ism_pkg::MIT_TMR_W]),
    .tick     (s.tick),
    .event_in (rx_done),
    .flush    (rx_step.suspended | rx_step.stopped),
    .fire     (rx_fire)
  );

  ism_mitigator u_tx_mit (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .cnt_cfg  (s.mitig[ism_pkg::MIT_TX_CNT_LSB +: ism_pkg::MIT_CNT_W]),
    .tmr_cfg  (s.mitig[ism_pkg::MIT_TX_TMR_LSB +: ism_pkg::MIT_TMR_W]),
    .tick     (s.tick),
    .event_in (tx_done),
    .flush    (tx_step.suspended | tx_step.stopped),
    .fire     (tx_fire)
  );

  // RL17: accesses are dropped until the reset sequence ends
  assign wr_ok = reg_wr && s.ready;
  assign rd_ok = reg_rd && s.ready;

  always_comb
  begin
    next_s = s;
    set_bits = '0;
    clr_bits = '0;

    // Mitigation time base
    // Free running: a timer's first step may fall short by up to a tick
    next_s.tick = 1'b0;
    if (s.tick_cnt == ism_pkg::TICK_LAST)
    begin
      next_s.tick_cnt = '0;
      next_s.tick = 1'b1;
    end
    else
      next_s.tick_cnt = s.tick_cnt + 8'h1;

    // Reset sequence
    if (!s.ready)
    begin
      next_s.wait_cnt = s.wait_cnt + 6'h1;
      if (s.wait_cnt == ism_pkg::RESET_WAIT_LAST)
        next_s.ready = 1'b1;
    end

    next_s.rx_st = rx_step.state;
    next_s.tx_st = tx_step.state;
    next_s.rx_acq = rx_step.acquire;
    next_s.tx_acq = tx_step.acquire;

    // Event collection; done events arrive only through mitigation
    set_bits = ev_in & ism_pkg::EVENT_MASK & ~ism_pkg::MITIGATED;
    set_bits[ism_pkg::ST_RX_DONE] = rx_fire;
    set_bits[ism_pkg::ST_TX_DONE] = tx_fire;
    set_bits = proc_events(set_bits, rx_step, ism_pkg::ST_RX_STOPPED,
                           ism_pkg::ST_RX_UNAVAIL);
    set_bits = proc_events(set_bits, tx_step, ism_pkg::ST_TX_STOPPED,
                           ism_pkg::ST_TX_UNAVAIL);

    // Register writes
    if (wr_ok)
    begin
      case (reg_addr)
        ism_pkg::OFS_BUS_MODE:
          next_s.bus_mode = reg_wdata;
        ism_pkg::OFS_OPER_MODE:
          next_s.oper_mode = reg_wdata & ism_pkg::OPER_MODE_MASK;
        ism_pkg::OFS_INT_STATUS:
          // RL5: write one to clear
          clr_bits = reg_wdata & ism_pkg::EVENT_MASK;
        ism_pkg::OFS_INT_ENABLE:
          next_s.enable = reg_wdata & ism_pkg::EVENT_MASK;
        ism_pkg::OFS_MITIGATION:
          next_s.mitig = reg_wdata & ism_pkg::MITIGATION_MASK;
        default:
          next_s.bus_mode = s.bus_mode;
      endcase
    end

    // RL22: latching ignores the enables; a new event beats its clear
    next_s.status = (s.status & ~clr_bits) | set_bits;

    // RL9: one level serves every cause
    // RL8: level of held bits, so recurrences add nothing
    // RL2: normal group
    // RL3: abnormal group
    any_sum = group_sum(next_s.status, next_s.enable,
                        ism_pkg::NORMAL_GROUP)
            | group_sum(next_s.status, next_s.enable,
                        ism_pkg::ABNORMAL_GROUP);
    clr_hit = |(clr_bits & s.status);
    // RL10: a clearing write forces one idle cycle on the line
    // RL4: drive while a summary is set
    // RL7: release when both clear
    next_s.int_act = any_sum && !clr_hit;

    // Read data stands only in the cycle after the strobe
    next_s.rdata = '0;
    if (rd_ok)
    begin
      case (reg_addr)
        ism_pkg::OFS_BUS_MODE:
          next_s.rdata = s.bus_mode;
        ism_pkg::OFS_OPER_MODE:
          next_s.rdata = s.oper_mode;
        ism_pkg::OFS_INT_STATUS:
          next_s.rdata = status_view(s.status, s.enable, s.rx_st, s.tx_st);
        ism_pkg::OFS_INT_ENABLE:
          next_s.rdata = s.enable;
        ism_pkg::OFS_MITIGATION:
          next_s.rdata = s.mitig;
        default:
          next_s.rdata = '0;
      endcase
    end

    // Soft reset clears all top-level state, including the wait sequence; the mitigators keep theirs
    if (wr_ok && reg_addr == ism_pkg::OFS_BUS_MODE
        && reg_wdata[ism_pkg::SOFT_RESET_BIT])
      next_s = '0;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign reg_rdata = s.rdata;
  assign rx_running = s.rx_st == ism_pkg::PROC_RUNNING;
  assign tx_running = s.tx_st == ism_pkg::PROC_RUNNING;
  assign rx_acquire = s.rx_acq;
  assign tx_acquire = s.tx_acq;
  assign dev_ready = s.ready;
  // From a flop, so the pin never glitches while set and clear merge
  assign int_n = ~s.int_act;

endmodule

/* verification/ism_host_irq.sv */
module ism_host_irq (
  // Clock and reset
  input  wire logic  mclk,
  input  wire logic  arst_n,
  // Interrupt line from the device
  input  wire logic  int_n,
  // Requests seen so far
  output int unsigned n_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic int_q;

  // Level input: only a high to low change is a new request
  always @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      int_q <= 1'b1;
      n_irq <= 0;
    end
    else
    begin
      int_q <= int_n;
      if (int_q && !int_n)
        n_irq <= n_irq + 1;
    end
endmodule

/* verification/ism_top_monitor.sv */
module ism_top_monitor (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        arst_n,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // Process and host side
  input wire logic        rx_running,
  input wire logic        tx_running,
  input wire logic        rx_acquire,
  input wire logic        tx_acquire,
  input wire logic        dev_ready,
  input wire logic        int_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] idle_cnt;
  logic       st_rd;

  // Saturates so a long wait cannot wrap below the limit
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
      idle_cnt <= 7'h00;
    else if (dev_ready)
      idle_cnt <= 7'h00;
    else if (idle_cnt != 7'h7f)
      idle_cnt <= idle_cnt + 7'h01;

  assign st_rd = reg_rd && dev_ready &&
                 reg_addr == ism_pkg::OFS_INT_STATUS;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  sequence s_rx_acq;
    rx_acquire ##1 !rx_acquire;
  endsequence
  sequence s_tx_acq;
    tx_acquire ##1 !tx_acquire;
  endsequence

  chk_ready_wait:
    assert property ($rose(dev_ready) |-> idle_cnt >= 7'h32)
    else $error("device ready too early after reset");
  chk_early_rd:
    assert property (reg_rd && !dev_ready |=> reg_rdata == 32'h0)
    else $error("read before ready returned data");
  chk_soft_rst:
    assert property (reg_wr && dev_ready && reg_wdata[0] &&
      reg_addr == ism_pkg::OFS_BUS_MODE |=> !dev_ready && int_n)
    else $error("soft reset did not restart the device");
  chk_ready_int:
    assert property (!dev_ready |-> int_n)
    else $error("interrupt during reset sequence");
  chk_int_cause:
    assert property ($past(st_rd) && !$past(int_n) |->
      reg_rdata[ism_pkg::ST_NOR_SUM] || reg_rdata[ism_pkg::ST_ABN_SUM])
    else $error("interrupt low with no summary set");
  chk_int_free:
    assert property ($past(st_rd) && !reg_rdata[ism_pkg::ST_NOR_SUM] &&
      !reg_rdata[ism_pkg::ST_ABN_SUM] |-> $past(int_n))
    else $error("interrupt low with both summaries clear");
  chk_clear_gap:
    assert property (reg_wr && dev_ready && !int_n &&
      reg_addr == ism_pkg::OFS_INT_STATUS &&
      reg_wdata == 32'hffff_ffff |=> int_n)
    else $error("clearing write kept the interrupt low");
  chk_rx_acq:
    assert property ($rose(rx_running) |-> s_rx_acq)
    else $error("receive ran without acquire pulse");
  chk_tx_acq:
    assert property ($rose(tx_running) |-> s_tx_acq)
    else $error("transmit ran without acquire pulse");
  chk_acq_cause:
    assert property (rx_acquire |-> $rose(rx_running))
    else $error("receive acquire outside entry to running");
endmodule

bind ism_top ism_top_monitor mon_u (
  .mclk       (mclk),
  .arst_n     (arst_n),
  .reg_addr   (reg_addr),
  .reg_wdata  (reg_wdata),
  .reg_wr     (reg_wr),
  .reg_rd     (reg_rd),
  .reg_rdata  (reg_rdata),
  .rx_running (rx_running),
  .tx_running (tx_running),
  .rx_acquire (rx_acquire),
  .tx_acquire (tx_acquire),
  .dev_ready  (dev_ready),
  .int_n      (int_n)
);

/* verification/tb_ism_top.sv */
module tb_ism_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] RXD = 6'h01;
  localparam logic [5:0] TXD = 6'h02;
  localparam logic [5:0] RXU = 6'h04;
  localparam logic [5:0] RXP = 6'h08;
  logic        mclk;
  logic        arst_n;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [31:0] ev_in;
  logic [5:0]  ctl;
  logic        rx_busy;
  logic        tx_busy;
  logic        rx_running;
  logic        tx_running;
  logic        dev_ready;
  logic        int_n;
  logic        rd_q;
  logic [31:0] seed;
  logic [31:0] exp_q[$];
  int unsigned n_irq;
  int          n_mismatch;
  int          n_tests;

  ism_top dut_u (
    .mclk           (mclk),
    .arst_n         (arst_n),
    .reg_addr       (reg_addr),
    .reg_wdata      (reg_wdata),
    .reg_wr         (reg_wr),
    .reg_rd         (reg_rd),
    .reg_rdata      (reg_rdata),
    .ev_in          (ev_in),
    .rx_done        (ctl[0]),
    .tx_done        (ctl[1]),
    .rx_buf_unavail (ctl[2]),
    .rx_poll        (ctl[3]),
    .rx_busy        (rx_busy),
    .tx_buf_unavail (ctl[4]),
    .tx_poll        (ctl[5]),
    .tx_busy        (tx_busy),
    .rx_running     (rx_running),
    .tx_running     (tx_running),
    .rx_acquire     (),
    .tx_acquire     (),
    .dev_ready      (dev_ready),
    .int_n          (int_n)
  );
  ism_host_irq host_u (
    .mclk   (mclk),
    .arst_n (arst_n),
    .int_n  (int_n),
    .n_irq  (n_irq)
  );

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] sums(input logic [31:0] m);
    sums = m;
    if (|(m & ism_pkg::NORMAL_GROUP))
      sums[ism_pkg::ST_NOR_SUM] = 1'b1;
    if (|(m & ism_pkg::ABNORMAL_GROUP))
      sums[ism_pkg::ST_ABN_SUM] = 1'b1;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask

  task automatic wrs(input logic [31:0] d);
    wr(ism_pkg::OFS_INT_STATUS, d);
  endtask

  task automatic rds(input logic [31:0] e);
    rd(ism_pkg::OFS_INT_STATUS, e);
  endtask

  task automatic pulse(input logic [31:0] e, input logic [5:0] c);
    @(posedge mclk);
    ev_in <= e;
    ctl <= c;
    @(posedge mclk);
    ev_in <= 32'h0;
    ctl <= 6'h0;
  endtask

  task automatic wait_ready();
    for (int i = 0; i < 100 && dev_ready !== 1'b1; i++)
      @(posedge mclk);
    check(dev_ready, 1'b1);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge mclk)
    rd_q <= reg_rd;
  always @(negedge mclk)
    if (rd_q)
      check(reg_rdata, exp_q.pop_front());

  initial
  begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    complete_run();
  end

  initial
  begin
    logic [31:0] v;
    logic [31:0] s;
    int unsigned n0;
    int          i;
    arst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ev_in = 32'h0;
    ctl = 6'h0;
    rx_busy = 1'b0;
    tx_busy = 1'b0;
    seed = 32'hc7c231c1;
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    rds(32'h0);
    wait_ready();
    for (i = 0; i < 6; i++)
      rd(8'(i * 4), 32'h0);
    v = xs() & 32'hffff_fffe;
    wr(ism_pkg::OFS_BUS_MODE, v);
    rd(ism_pkg::OFS_BUS_MODE, v);
    v = xs();
    wr(ism_pkg::OFS_MITIGATION, v);
    rd(ism_pkg::OFS_MITIGATION, v & ism_pkg::MITIGATION_MASK);
    wr(ism_pkg::OFS_MITIGATION, 32'h0);
    $display("test registers done");
    wr(ism_pkg::OFS_INT_ENABLE, ism_pkg::EVENT_MASK);
    for (i = 1; i < 32; i++)
      if (ism_pkg::EVENT_MASK[i] && i != ism_pkg::ST_RX_DONE)
      begin
        s = 32'h1 << i;
        pulse(s, 6'h0);
        @(negedge mclk);
        check(int_n, 1'b0);
        wrs(~s);
        rds(sums(s));
        wrs(s);
        @(negedge mclk);
        check(int_n, 1'b1);
        rds(32'h0);
      end
    $display("test groups done");
    for (i = 0; i < 8; i++)
    begin
      v = xs() & ism_pkg::EVENT_MASK & ~ism_pkg::MITIGATED;
      s = xs();
      wr(ism_pkg::OFS_INT_ENABLE, s);
      pulse(v, 6'h0);
      @(negedge mclk);
      check(int_n, !(|(v & s)));
      rds(v | sums(v & s));
      wrs(32'hffff_ffff);
    end
    $display("test masking done");
    wr(ism_pkg::OFS_INT_ENABLE, ism_pkg::EVENT_MASK);
    n0 = n_irq;
    pulse(32'h804, 6'h0);
    pulse(32'h4, 6'h0);
    repeat (3) @(negedge mclk);
    check(n_irq - n0, 32'h1);
    pulse(32'h80, 6'h0);
    wrs(32'h804);
    @(negedge mclk);
    check(int_n, 1'b1);
    @(negedge mclk);
    check(int_n, 1'b0);
    @(negedge mclk);
    check(n_irq - n0, 32'h2);
    wrs(32'hffff_ffff);
    rds(32'h0);
    $display("test requeue done");
    wr(ism_pkg::OFS_MITIGATION, 32'h2 << ism_pkg::MIT_RX_CNT_LSB);
    for (i = 0; i < 2; i++)
    begin
      pulse(32'h0, RXD);
      rds(32'h0);
      pulse(32'h0, RXD);
      rds(sums(32'h40));
      wrs(32'h40);
    end
    wr(ism_pkg::OFS_MITIGATION, 32'h2 << ism_pkg::MIT_TX_TMR_LSB);
    pulse(32'h0, TXD);
    rds(32'h0);
    // Tick phase is free running, so allow one tick of slack
    for (i = 0; i < 400 && int_n === 1'b1; i++)
      @(negedge mclk);
    check(i >= 120 && i <= 270, 1'b1);
    rds(sums(32'h1));
    wrs(32'h1);
    wr(ism_pkg::OFS_MITIGATION, 32'h0);
    pulse(32'h0, RXD | TXD);
    @(negedge mclk);
    check(int_n, 1'b0);
    rds(sums(32'h41));
    wrs(32'hffff_ffff);
    $display("test mitigation done");
    wr(ism_pkg::OFS_MITIGATION, 32'h3 << ism_pkg::MIT_RX_CNT_LSB);
    // no serial or filter setup needed, start directly
    wr(ism_pkg::OFS_OPER_MODE, 32'h1);
    repeat (2) @(negedge mclk);
    check({rx_running, tx_running}, 2'b10);
    pulse(32'h0, RXD);
    rds(32'h1 << ism_pkg::ST_RX_STATE);
    pulse(32'h0, RXU);
    rds(32'h780c0);
    wrs(32'hc0);
    pulse(32'h0, RXP);
    repeat (2) @(negedge mclk);
    check(rx_running, 1'b1);
    wr(ism_pkg::OFS_OPER_MODE, 32'h3);
    repeat (2) @(negedge mclk);
    check({rx_running, tx_running}, 2'b11);
    wr(ism_pkg::OFS_OPER_MODE, 32'h2);
    rds(32'h108100);
    // A frame in flight holds off the stop
    tx_busy <= 1'b1;
    wr(ism_pkg::OFS_OPER_MODE, 32'h0);
    rds(32'h108100);
    tx_busy <= 1'b0;
    rds(32'h8102);
    wrs(32'hffff_ffff);
    $display("test processes done");
    wr(ism_pkg::OFS_BUS_MODE, 32'h1);
    @(negedge mclk);
    check(dev_ready, 1'b0);
    wr(ism_pkg::OFS_INT_ENABLE, 32'hffff_ffff);
    wait_ready();
    rd(ism_pkg::OFS_INT_ENABLE, 32'h0);
    rd(ism_pkg::OFS_BUS_MODE, 32'h0);
    $display("test soft reset done");
    complete_run();
  end
endmodule
